// file: pnp_pkg.sv
// Shared constants and types for the configuration resource readout block
`default_nettype none

package pnp_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS   = 50;
  localparam int unsigned EE_SK_HALF_NS   = 500;
  localparam int unsigned EE_SK_HALF_CYC  =
    (EE_SK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Serial store word map
  // ----------------------------------------------------------------
  localparam logic [5:0] EE_W_STATION0   = 6'h00;
  localparam logic [5:0] EE_W_CFG_AB     = 6'h0E;
  localparam logic [5:0] EE_W_CFG_MODE   = 6'h0F;
  localparam logic [5:0] EE_W_VENDOR0    = 6'h10;
  localparam logic [5:0] EE_W_SERIAL0    = 6'h12;
  localparam logic [5:0] EE_W_CSUM_RES   = 6'h14;
  localparam logic [5:0] EE_W_LAST       = 6'h3F;
  localparam logic [2:0] BOOT_WORDS      = 3'h5;

  // Byte stream: identifier bytes then resource bytes, one pointer
  localparam logic [6:0] SERIAL_ID_BYTES = 7'h09;
  localparam logic [6:0] STREAM_LAST     = 7'h5F;

  // ----------------------------------------------------------------
  // Operating mode codes and status layout
  // ----------------------------------------------------------------
  localparam logic [7:0] MODE_JUMPERLESS_CODE = 8'h4A;
  localparam logic [7:0] MODE_PNP_CODE        = 8'h50;
  localparam int unsigned STATUS_READY_BIT    = 0;
  localparam logic [7:0] RES_DATA_RESET       = 8'h00;
  localparam logic [7:0] HANDLE_RESET         = 8'h00;

  // ----------------------------------------------------------------
  // Three-wire serial store framing
  // ----------------------------------------------------------------
  localparam logic [1:0] EE_OP_READ      = 2'h2;
  localparam logic [4:0] EE_CMD_BITS     = 5'h09;
  localparam logic [4:0] EE_SAMPLE_FIRST = 5'h0A;
  localparam logic [4:0] EE_FRAME_LAST   = 5'h1A;

  localparam int unsigned FIFO_DEPTH     = 4;

  typedef enum logic [1:0] {
    PNP_OPM_AUTO,
    PNP_OPM_JUMPERLESS,
    PNP_OPM_PNP
  } pnp_opmode_e;

  typedef enum logic [1:0] {
    PNP_CS_SLEEP,
    PNP_CS_ISOL,
    PNP_CS_CONFIG
  } pnp_card_e;

  typedef struct packed {
    logic [47:0] station;
    logic [7:0]  cfg_a;
    logic [7:0]  cfg_b;
    logic [7:0]  cfg_c;
    pnp_opmode_e mode;
  } pnp_cfg_s;

endpackage

`default_nettype wire

// file: pnp_fifo.sv
// Small flip-flop FIFO with valid/ready on both sides and a flush
`default_nettype none

module pnp_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 4
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             flush_i,
  // Fill side
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  // Drain side
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);

  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int unsigned CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
  localparam logic [AW-1:0] LAST_IX  = AW'(DEPTH - 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ix;
  logic [AW-1:0]    rd_ix;
  logic [CW-1:0]    count;

  wire push = in_valid_i && in_ready_o;
  wire pop  = out_valid_o && out_ready_i;

  assign in_ready_o  = (count != FULL_CNT) && !flush_i;
  assign out_valid_o = (count != '0) && !flush_i;
  assign out_data_o  = mem[rd_ix];

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  for (genvar g = 0; g < DEPTH; g++) begin : g_entry
    always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i)
        mem[g] <= '0;
      else if (push && wr_ix == AW'(g))
        mem[g] <= in_data_i;
    end
  end

  // ----------------------------------------------------------------
  // Pointers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_ix <= '0;
      rd_ix <= '0;
      count <= '0;
    end else if (flush_i) begin
      wr_ix <= '0;
      rd_ix <= '0;
      count <= '0;
    end else begin
      if (push)
        wr_ix <= (wr_ix == LAST_IX) ? '0 : wr_ix + 1'b1;
      if (pop)
        rd_ix <= (rd_ix == LAST_IX) ? '0 : rd_ix + 1'b1;
      if (push && !pop)
        count <= count + 1'b1;
      else if (pop && !push)
        count <= count - 1'b1;
    end
  end

endmodule

`default_nettype wire

// file: pnp_ee_rd.sv
// Three-wire serial store word reader: start, read opcode, address, 16 data bits
`default_nettype none

module pnp_ee_rd
  import pnp_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Word request
  input  wire logic        req_i,
  input  wire logic [5:0]  addr_i,
  output logic             busy_o,
  output logic             done_o,
  output logic      [15:0] word_o,
  // Serial store pins
  output logic             ee_cs_o,
  output logic             ee_sk_o,
  output logic             ee_di_o,
  input  wire logic        ee_do_i
);

  localparam logic [3:0] HALF_LAST = 4'(EE_SK_HALF_CYC - 1);

  logic [3:0] div;
  logic [4:0] idx;
  logic [8:0] cmd;

  wire half_end  = busy_o && (div == HALF_LAST);
  wire low_end   = half_end && !ee_sk_o;
  wire high_end  = half_end && ee_sk_o;
  wire sample    = low_end && (idx >= EE_SAMPLE_FIRST) && (idx < EE_FRAME_LAST);
  wire frame_end = high_end && (idx == EE_FRAME_LAST);

  // Last period keeps select low to give the part its deselect time
  assign ee_cs_o = busy_o && (idx != EE_FRAME_LAST);
  assign ee_di_o = busy_o && (idx < EE_CMD_BITS) && cmd[8];

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      busy_o  <= 1'b0;
      done_o  <= 1'b0;
      ee_sk_o <= 1'b0;
      div     <= '0;
      idx     <= '0;
      cmd     <= '0;
      word_o  <= '0;
    end else begin
      done_o <= frame_end;
      if (!busy_o) begin
        if (req_i) begin
          busy_o <= 1'b1;
          div    <= '0;
          idx    <= '0;
          cmd    <= {1'b1, EE_OP_READ, addr_i};
        end
      end else begin
        div <= half_end ? '0 : div + 1'b1;
        if (sample)
          word_o <= {word_o[14:0], ee_do_i};
        if (low_end)
          ee_sk_o <= 1'b1;
        if (high_end) begin
          ee_sk_o <= 1'b0;
          idx     <= idx + 1'b1;
          cmd     <= {cmd[7:0], 1'b0};
        end
        if (frame_end)
          busy_o <= 1'b0;
      end
    end
  end

endmodule

`default_nettype wire

// file: pnp_readout.sv
// Configuration resource-data readout: card state, serial store, byte register
//
// How it works
// - Resource bytes are returned and read only while the card is in Config.
// - Config is entered on isolation win with handle, or matching wake.
// - Identifier and resource bytes form one stream behind one pointer.
// - Every wake command returns the pointer to the identifier start.
// - Identifier after wake gives true vendor and serial bytes; checksum may not.
// - Config entered from isolation gives resource data on the first read.
// - Eight bits gather in the data register, then status bit 0 sets.
// - Reading the data register clears bit 0 and shifts in the next byte.
// - Store map: vendor 10H-11H, serial 12H-13H, checksum 14H low, resource after.
// - Word 0FH high byte picks mode: 4AH jumperless, 50H plug-in, else auto.
// - Each byte is shifted bit 0 first through bit 7 last.
// - After reset or config reset the store is loaded; host waits 2 ms.
`default_nettype none

module pnp_readout
  import pnp_pkg::*;
(
  // Clock and reset
  input  wire logic       CLK_SYS_I,
  input  wire logic       SYS_RST_I,
  // Card state events from isolation and command decode
  input  wire logic       ISO_WIN_I,
  input  wire logic [7:0] ISO_HANDLE_I,
  input  wire logic       WAKE_I,
  input  wire logic [7:0] WAKE_DATA_I,
  input  wire logic       CFG_RESET_I,
  // Resource data and status registers
  input  wire logic       RES_RD_I,
  output logic      [7:0] RES_DATA_O,
  output logic      [7:0] STATUS_O,
  // Card state and loaded configuration
  output pnp_card_e       CARD_STATE_O,
  output logic      [7:0] HANDLE_O,
  output logic            LOAD_BUSY_O,
  output pnp_cfg_s        CFG_O,
  // Serial store pins
  output logic            EE_CS_O,
  output logic            EE_SK_O,
  output logic            EE_DI_O,
  input  wire logic       EE_DO_I
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  pnp_card_e   card;
  pnp_card_e   next_card;
  logic [7:0]  handle;
  logic [6:0]  fetch_ptr;
  logic [2:0]  load_ix;
  logic        load_busy;
  logic        req_load;
  logic        req_hi;
  logic        stale;
  logic        ready;
  logic        sh_busy;
  logic [2:0]  sh_cnt;
  logic [7:0]  sh_src;
  logic [7:0]  res_data;
  pnp_cfg_s    cfg;

  logic        ee_busy;
  logic        ee_done;
  logic [15:0] ee_word;
  logic        fifo_in_ready;
  logic        fifo_out_valid;
  logic [7:0]  fifo_out_data;

  // ----------------------------------------------------------------
  // Card state decode
  // ----------------------------------------------------------------
  wire in_config = (card == PNP_CS_CONFIG);
  wire iso_win   = ISO_WIN_I && (card == PNP_CS_ISOL);
  wire wake_hit  = WAKE_I && (handle != HANDLE_RESET) && (WAKE_DATA_I == handle);
  wire wake_iso  = WAKE_I && (handle == HANDLE_RESET) && (WAKE_DATA_I == HANDLE_RESET);
  wire flush     = WAKE_I || iso_win || CFG_RESET_I;

  always_comb begin
    next_card = card;
    case (card)
      PNP_CS_SLEEP: begin
        if (wake_hit)
          next_card = PNP_CS_CONFIG;
        else if (wake_iso)
          next_card = PNP_CS_ISOL;
      end
      PNP_CS_ISOL: begin
        if (iso_win)
          next_card = PNP_CS_CONFIG;
        else if (WAKE_I)
          next_card = wake_iso ? PNP_CS_ISOL : PNP_CS_SLEEP;
      end
      PNP_CS_CONFIG: begin
        if (WAKE_I && !wake_hit)
          next_card = wake_iso ? PNP_CS_ISOL : PNP_CS_SLEEP;
      end
      default: next_card = PNP_CS_SLEEP;
    endcase
    if (CFG_RESET_I)
      next_card = PNP_CS_SLEEP;
  end

  always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      card   <= PNP_CS_SLEEP;
      handle <= HANDLE_RESET;
    end else begin
      card <= next_card;
      if (iso_win)
        handle <= ISO_HANDLE_I;
    end
  end

  // ----------------------------------------------------------------
  // Store request arbitration
  // ----------------------------------------------------------------
  // Boot word list
  wire [5:0] boot_addr = (load_ix == 3'h3) ? EE_W_CFG_AB :
                         (load_ix == 3'h4) ? EE_W_CFG_MODE :
                         EE_W_STATION0 + 6'(load_ix);
  wire [5:0] stream_addr = EE_W_VENDOR0 + 6'(fetch_ptr[6:1]);
  // Fetch only in Config
  // Done cycle waits: boot index and queue count catch up on that edge
  wire stream_req = in_config && !load_busy && !ee_busy && !ee_done && !flush &&
                    (fetch_ptr <= STREAM_LAST) && fifo_in_ready;
  wire load_req   = load_busy && !ee_busy && !ee_done && !CFG_RESET_I;
  wire ee_req     = load_req || stream_req;
  wire [5:0] ee_addr = load_busy ? boot_addr : stream_addr;
  wire [7:0] ee_byte = req_hi ? ee_word[15:8] : ee_word[7:0];
  // Checksum byte passed on as stored
  wire push = ee_done && !req_load && !stale;

  always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      fetch_ptr <= '0;
      req_load  <= 1'b0;
      req_hi    <= 1'b0;
      stale     <= 1'b0;
    end else begin
      if (ee_req) begin
        req_load <= load_busy;
        req_hi   <= fetch_ptr[0];
      end
      // A word in flight across a pointer reset must not enter the stream
      if (flush && ee_busy)
        stale <= 1'b1;
      else if (ee_done)
        stale <= 1'b0;
      if (WAKE_I || CFG_RESET_I)
        fetch_ptr <= '0;
      else if (iso_win)
        fetch_ptr <= SERIAL_ID_BYTES;
      else if (stream_req)
        fetch_ptr <= fetch_ptr + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Initial configuration load
  // ----------------------------------------------------------------
  // Mode code decode
  wire [7:0] mode_code = ee_word[15:8];
  wire pnp_opmode_e mode_dec = (mode_code == MODE_JUMPERLESS_CODE) ? PNP_OPM_JUMPERLESS :
                               (mode_code == MODE_PNP_CODE) ? PNP_OPM_PNP : PNP_OPM_AUTO;
  // A word fetched across a config reset is dropped
  wire load_take = ee_done && req_load && !stale;

  always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      load_busy <= 1'b1;
      load_ix   <= '0;
      cfg       <= '0;
    end else if (CFG_RESET_I) begin
      load_busy <= 1'b1;
      load_ix   <= '0;
    end else if (load_take) begin
      case (load_ix)
        3'h0: cfg.station[15:0]  <= ee_word;
        3'h1: cfg.station[31:16] <= ee_word;
        3'h2: cfg.station[47:32] <= ee_word;
        3'h3: begin
          cfg.cfg_a <= ee_word[7:0];
          cfg.cfg_b <= ee_word[15:8];
        end
        3'h4: begin
          cfg.cfg_c <= ee_word[7:0];
          cfg.mode  <= mode_dec;
        end
        default: cfg <= cfg;
      endcase
      load_ix <= load_ix + 1'b1;
      if (load_ix == BOOT_WORDS - 3'h1)
        load_busy <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Byte assembly into the resource data register
  // ----------------------------------------------------------------
  // Reads outside Config have no effect
  wire rd_ok   = RES_RD_I && in_config;
  wire pop     = fifo_out_valid && !sh_busy && !ready && in_config;
  wire sh_last = sh_busy && (sh_cnt == 3'h7);

  always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      sh_busy  <= 1'b0;
      sh_cnt   <= '0;
      sh_src   <= '0;
      res_data <= RES_DATA_RESET;
    end else if (flush) begin
      sh_busy <= 1'b0;
      sh_cnt  <= '0;
    end else if (pop) begin
      sh_busy <= 1'b1;
      sh_cnt  <= '0;
      sh_src  <= fifo_out_data;
    end else if (sh_busy) begin
      res_data <= {sh_src[0], res_data[7:1]};
      sh_src   <= {1'b0, sh_src[7:1]};
      sh_cnt   <= sh_cnt + 1'b1;
      if (sh_last)
        sh_busy <= 1'b0;
    end
  end

  always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
    if (SYS_RST_I)
      ready <= 1'b0;
    else if (flush)
      ready <= 1'b0;
    else if (sh_last)
      ready <= 1'b1;
    else if (rd_ok)
      ready <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Flag held clear while shifting
  assign STATUS_O     = {7'h00, ready && in_config};
  assign RES_DATA_O   = res_data;
  assign CARD_STATE_O = card;
  assign HANDLE_O     = handle;
  assign LOAD_BUSY_O  = load_busy;
  assign CFG_O        = cfg;

  // ----------------------------------------------------------------
  // Submodules
  // ----------------------------------------------------------------
  pnp_ee_rd u_ee (
    .clk_i   (CLK_SYS_I),
    .rst_i   (SYS_RST_I),
    .req_i   (ee_req),
    .addr_i  (ee_addr),
    .busy_o  (ee_busy),
    .done_o  (ee_done),
    .word_o  (ee_word),
    .ee_cs_o (EE_CS_O),
    .ee_sk_o (EE_SK_O),
    .ee_di_o (EE_DI_O),
    .ee_do_i (EE_DO_I)
  );

  pnp_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (CLK_SYS_I),
    .rst_i       (SYS_RST_I),
    .flush_i     (flush),
    .in_valid_i  (push),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (ee_byte),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (pop),
    .out_data_o  (fifo_out_data)
  );

endmodule

`default_nettype wire

// file: pnp_readout_properties.sv
// Concurrent checks on the resource readout block's ports
`default_nettype none

module pnp_readout_properties
  import pnp_pkg::*;
(
  // Clock and reset
  input wire logic       CLK_SYS_I,
  input wire logic       SYS_RST_I,
  // Events and register port
  input wire logic       ISO_WIN_I,
  input wire logic [7:0] ISO_HANDLE_I,
  input wire logic       WAKE_I,
  input wire logic [7:0] WAKE_DATA_I,
  input wire logic       CFG_RESET_I,
  input wire logic       RES_RD_I,
  input wire logic [7:0] RES_DATA_O,
  input wire logic [7:0] STATUS_O,
  // State and store pins
  input wire pnp_card_e  CARD_STATE_O,
  input wire logic [7:0] HANDLE_O,
  input wire logic       LOAD_BUSY_O,
  input wire logic       EE_CS_O,
  input wire logic       EE_SK_O,
  input wire logic       EE_DI_O
);
  default clocking @(posedge CLK_SYS_I); endclocking
  default disable iff (SYS_RST_I);

  property p_status_upper;
    STATUS_O[7:1] == 7'h00;
  endproperty
  a_status_upper: assert property (p_status_upper) else $error("status upper bits set");

  property p_ready_config;
    STATUS_O[0] |-> CARD_STATE_O == PNP_CS_CONFIG;
  endproperty
  a_ready_config: assert property (p_ready_config) else $error("ready outside config");

  property p_read_outside;
    RES_RD_I && CARD_STATE_O != PNP_CS_CONFIG |=> !STATUS_O[0] && $stable(RES_DATA_O);
  endproperty
  a_read_outside: assert property (p_read_outside) else $error("read served outside config");

  property p_read_clear;
    STATUS_O[0] && RES_RD_I |=> !STATUS_O[0] [*8];
  endproperty
  a_read_clear: assert property (p_read_clear) else $error("ready back too soon");

  property p_data_stable;
    STATUS_O[0] && !RES_RD_I && !WAKE_I && !ISO_WIN_I && !CFG_RESET_I |=> $stable(RES_DATA_O);
  endproperty
  a_data_stable: assert property (p_data_stable) else $error("data moved while ready");

  property p_wake_match;
    WAKE_I && WAKE_DATA_I == HANDLE_O && HANDLE_O != 8'h00 |=> CARD_STATE_O == PNP_CS_CONFIG;
  endproperty
  a_wake_match: assert property (p_wake_match) else $error("matching wake missed");

  property p_iso_win;
    ISO_WIN_I && CARD_STATE_O == PNP_CS_ISOL
      |=> CARD_STATE_O == PNP_CS_CONFIG && HANDLE_O == $past(ISO_HANDLE_I);
  endproperty
  a_iso_win: assert property (p_iso_win) else $error("isolation win missed");

  property p_wake_drop;
    WAKE_I |=> !STATUS_O[0];
  endproperty
  a_wake_drop: assert property (p_wake_drop) else $error("ready kept over wake");

  property p_ee_start;
    $rose(EE_CS_O) |-> EE_DI_O && !EE_SK_O ##10 EE_SK_O;
  endproperty
  a_ee_start: assert property (p_ee_start) else $error("bad store frame start");

  property p_cfg_reset;
    CFG_RESET_I |=> CARD_STATE_O == PNP_CS_SLEEP ##[0:2] LOAD_BUSY_O;
  endproperty
  a_cfg_reset: assert property (p_cfg_reset) else $error("config reset ignored");
endmodule

bind pnp_readout pnp_readout_properties i_props (.CLK_SYS_I, .SYS_RST_I, .ISO_WIN_I,
  .ISO_HANDLE_I, .WAKE_I, .WAKE_DATA_I, .CFG_RESET_I, .RES_RD_I, .RES_DATA_O, .STATUS_O,
  .CARD_STATE_O, .HANDLE_O, .LOAD_BUSY_O, .EE_CS_O, .EE_SK_O, .EE_DI_O);

`default_nettype wire

// file: pnp_ee_model.sv
// Behavioural three-wire serial store answering word reads
`default_nettype none

module pnp_ee_model (
  // Serial store pins
  input  wire logic       cs_i,
  input  wire logic       sk_i,
  input  wire logic       di_i,
  output logic            do_o,
  // Byte held in word 0FH high
  input  wire logic [7:0] mode_byte_i
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [4:0]  cnt = 5'h00;
  logic [5:0]  addr = 6'h00;
  logic [15:0] word = 16'h0000;
  logic        out_bit = 1'b0;

  assign do_o = out_bit;

  function automatic logic [7:0] byte_at(input logic [6:0] n);
    byte_at = (n == 7'h1F) ? mode_byte_i : ({1'b0, n} ^ 8'hA5);
  endfunction

  // Released line shows the inverse, not a held value
  always @(posedge sk_i or negedge cs_i) begin
    if (!cs_i) begin
      if (cnt != 5'h00) begin
        cnt = 5'h00;
        out_bit = ~out_bit;
      end
    end else begin
      if (cnt >= 5'h03 && cnt <= 5'h08) begin
        addr = {addr[4:0], di_i};
      end
      if (cnt == 5'h08) begin
        word = {byte_at({addr, 1'b1}), byte_at({addr, 1'b0})};
      end
      if (cnt >= 5'h09 && cnt <= 5'h18) begin
        out_bit = word[5'd24 - cnt];
      end else if (cnt > 5'h18) begin
        out_bit = ~out_bit;
      end
      if (cnt != 5'h1F) begin
        cnt = cnt + 5'h01;
      end
    end
  end
endmodule

`default_nettype wire

// file: testbench.sv
// Self-checking bench for the resource readout block
`default_nettype none

module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import pnp_pkg::*;

  logic       clk_sys = 1'b0;
  logic       sys_rst = 1'b1;
  logic       iso_win = 1'b0;
  logic [7:0] iso_handle = 8'h00;
  logic       wake = 1'b0;
  logic [7:0] wake_data = 8'h00;
  logic       cfg_reset = 1'b0;
  logic       res_rd = 1'b0;
  logic [7:0] mode_byte = 8'h00;
  logic [7:0] res_data;
  logic [7:0] status;
  logic [7:0] handle;
  logic       load_busy;
  logic       ee_cs;
  logic       ee_sk;
  logic       ee_di;
  logic       ee_do;
  pnp_card_e  card_state;
  pnp_cfg_s   cfg;
  int         fail_count = 0;
  int         num_checks = 0;
  int         cyc = 0;

  always #25 clk_sys = ~clk_sys;

  pnp_readout i_dut (
    .CLK_SYS_I(clk_sys), .SYS_RST_I(sys_rst), .ISO_WIN_I(iso_win), .ISO_HANDLE_I(iso_handle),
    .WAKE_I(wake), .WAKE_DATA_I(wake_data), .CFG_RESET_I(cfg_reset), .RES_RD_I(res_rd),
    .RES_DATA_O(res_data), .STATUS_O(status), .CARD_STATE_O(card_state), .HANDLE_O(handle),
    .LOAD_BUSY_O(load_busy), .CFG_O(cfg), .EE_CS_O(ee_cs), .EE_SK_O(ee_sk), .EE_DI_O(ee_di),
    .EE_DO_I(ee_do)
  );

  pnp_ee_model i_ee (
    .cs_i(ee_cs), .sk_i(ee_sk), .di_i(ee_di), .do_o(ee_do), .mode_byte_i(mode_byte)
  );

  task automatic end_sim;
    $display("checks=%0d mismatches=%0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      fail_count++;
      end_sim;
    end
  end

  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      fail_count++;
    end
  endtask

  function automatic logic [7:0] stream_byte(input int k);
    stream_byte = 8'(8'h20 + k) ^ 8'hA5;
  endfunction

  // Kind 0 wake, 1 isolation win, 2 config reset, 3 data read
  task automatic pulse(input int kind, input logic [7:0] d);
    @(posedge clk_sys);
    wake       <= (kind == 0);
    iso_win    <= (kind == 1);
    cfg_reset  <= (kind == 2);
    res_rd     <= (kind == 3);
    wake_data  <= d;
    iso_handle <= d;
    @(posedge clk_sys);
    {wake, iso_win, cfg_reset, res_rd} <= 4'h0;
    @(posedge clk_sys);
  endtask

  task automatic do_reset(input logic [7:0] m);
    int n;
    mode_byte <= m;
    sys_rst <= 1'b1;
    repeat (3) @(posedge clk_sys);
    sys_rst <= 1'b0;
    n = 0;
    while (load_busy !== 1'b0 && n < 4000) begin
      @(posedge clk_sys);
      n++;
    end
    check8({7'h00, load_busy}, 8'h00);
  endtask

  task automatic read_byte(input logic [7:0] exp);
    int n;
    n = 0;
    while (status[0] !== 1'b1 && n < 3000) begin
      @(posedge clk_sys);
      n++;
    end
    check8(status, 8'h01);
    check8(res_data, exp);
    pulse(3, 8'h00);
    check8(status, 8'h00);
  endtask

  task automatic check_state(input pnp_card_e exp);
    check8({6'h00, card_state}, {6'h00, exp});
  endtask

  initial begin
    logic [7:0]  modes [3];
    pnp_opmode_e exp_mode [3];
    modes = '{8'h4A, 8'h50, 8'h33};
    exp_mode = '{PNP_OPM_JUMPERLESS, PNP_OPM_PNP, PNP_OPM_AUTO};
    for (int m = 0; m < 3; m++) begin
      do_reset(modes[m]);
      check8({6'h00, cfg.mode}, {6'h00, exp_mode[m]});
    end
    check8(cfg.cfg_a, 8'hB9);
    check8(cfg.cfg_b, 8'hB8);
    check8(cfg.cfg_c, 8'hBB);
    for (int b = 0; b < 6; b++) begin
      check8(cfg.station[8*b +: 8], 8'(b) ^ 8'hA5);
    end
    $display("test boot_load done");
    repeat (40000) @(posedge clk_sys);
    pulse(3, 8'h00);
    repeat (600) @(posedge clk_sys);
    check8(status, 8'h00);
    pulse(0, 8'h00);
    check_state(PNP_CS_ISOL);
    repeat (600) @(posedge clk_sys);
    check8(status, 8'h00);
    pulse(1, 8'h07);
    check_state(PNP_CS_CONFIG);
    check8(handle, 8'h07);
    for (int k = 9; k < 13; k++) begin
      read_byte(stream_byte(k));
    end
    $display("test isolation_path done");
    pulse(0, 8'h33);
    check_state(PNP_CS_SLEEP);
    check8(status, 8'h00);
    pulse(0, 8'h07);
    check_state(PNP_CS_CONFIG);
    for (int k = 0; k < 10; k++) begin
      read_byte(stream_byte(k));
    end
    pulse(0, 8'h07);
    read_byte(stream_byte(0));
    $display("test wake_path done");
    pulse(2, 8'h00);
    check_state(PNP_CS_SLEEP);
    check8(handle, 8'h07);
    check8({7'h00, load_busy}, 8'h01);
    pulse(1, 8'h55);
    check_state(PNP_CS_SLEEP);
    check8(handle, 8'h07);
    $display("test config_reset done");
    end_sim;
  end
endmodule

`default_nettype wire
